// ===== hw/psc_regs.vh
// constants of the strap configuration loader
`ifndef PSC_REGS_VH
`define PSC_REGS_VH
// ==========================================
// register byte addresses, index times four
`define PSC_IDX_CTRL    8'h00
`define PSC_IDX_ADV     8'h10
`define PSC_IDX_MODE    8'h48
`define PSC_IDX_STAT    8'h80
// ==========================================
// control, advertisement and mode field positions
`define PSC_CTL_SRST    15
`define PSC_CTL_SPEED   13
`define PSC_CTL_ANEG    12
`define PSC_CTL_ISO     10
`define PSC_CTL_DUPLEX  8
`define PSC_ADV_LSB     5
`define PSC_MODE_LSB    5
// ==========================================
// reset values, mode codes and scrambler seed pad
`define PSC_CTL_RST     4'h0
`define PSC_ADV_RST     4'h0
`define PSC_MODE_PD     3'h6
`define PSC_MODE_RPT    3'h5
`define PSC_SCR_PAD     6'h01
// ==========================================
// timing
`define PSC_CLK_MHZ     100
`define PSC_SRST_US     256
`define PSC_SRST_CYC    (`PSC_SRST_US * `PSC_CLK_MHZ)
`define PSC_REL_CYC     3'h4
`endif

// ===== hw/psc_strap_loader.v
// strap configuration loader with avalon register slave
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
`include "psc_regs.vh"

module psc_strap_loader #(
   parameter SOFT_RST_CYC = `PSC_SRST_CYC
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [4:0]  strap_station_address,
   input  wire [2:0]  strap_mode,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   input  wire        mgmt_frame_valid,
   input  wire [4:0]  mgmt_phy_addr,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg         mgmt_respond_q,
   output reg  [4:0]  station_address_q,
   output reg         speed_100_q,
   output reg         aneg_en_q,
   output reg         isolate_q,
   output reg         full_duplex_q,
   output reg  [3:0]  adv_q,
   output reg         crs_on_tx_q,
   output reg         repeater_q,
   output reg         power_down_q,
   output reg         soft_reset_q,
   output reg         config_valid_q,
   output reg         scr_bit_q
);

   localparam [31:0] SRST_LAST_W = SOFT_RST_CYC - 1;
   localparam [15:0] SRST_LAST   = SRST_LAST_W[15:0];

   // ==========================================
   // mode decode
   // control nibble in the order {ctl13, ctl12, ctl10, ctl8}
   function [3:0] preset_ctl;
      input [2:0] m;
      begin
         case (m)
            3'h0:    preset_ctl = 4'h0;
            3'h1:    preset_ctl = 4'h1;
            3'h2:    preset_ctl = 4'h8;
            3'h3:    preset_ctl = 4'h9;
            3'h4:    preset_ctl = 4'hc;
            3'h5:    preset_ctl = 4'hc;
            3'h6:    preset_ctl = 4'h0;
            // don't-care bits 13 and 8 come up set
            3'h7:    preset_ctl = 4'hd;
            default: preset_ctl = 4'h0;
         endcase
      end
   endfunction

   // advertisement nibble, bits 8..5
   function [3:0] preset_adv;
      input [2:0] m;
      begin
         case (m)
            3'h4:    preset_adv = 4'h4;
            3'h5:    preset_adv = 4'h4;
            3'h7:    preset_adv = 4'hf;
            default: preset_adv = 4'h0;
         endcase
      end
   endfunction

   // modes without an advertisement column leave adv_q alone
   function adv_loads;
      input [2:0] m;
      begin
         case (m)
            3'h4:    adv_loads = 1'b1;
            3'h5:    adv_loads = 1'b1;
            3'h7:    adv_loads = 1'b1;
            default: adv_loads = 1'b0;
         endcase
      end
   endfunction

   // carrier sense on transmit as well as receive
   // receive-only carrier sense is the default for the remaining codes
   function crs_tx;
      input [2:0] m;
      begin
         case (m)
            3'h0:    crs_tx = 1'b1;
            3'h2:    crs_tx = 1'b1;
            3'h4:    crs_tx = 1'b1;
            3'h7:    crs_tx = 1'b1;
            default: crs_tx = 1'b0;
         endcase
      end
   endfunction

   // register byte address match
   function hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         hit = (addr == offset);
      end
   endfunction

   // ==========================================
   // strap synchronizers
   // straps are static, so three flops per pin cost nothing and kill metastability
   reg [7:0] strap_s1_q;
   reg [7:0] strap_s2_q;
   reg [7:0] strap_s3_q;
   reg [7:0] strap_val_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_s1_q  <= 8'h00;
         strap_s2_q  <= 8'h00;
         strap_s3_q  <= 8'h00;
         strap_val_q <= 8'h00;
      end else begin
         strap_s1_q <= {strap_mode, strap_station_address};
         strap_s2_q <= strap_s1_q;
         strap_s3_q <= strap_s2_q;
         if (strap_s2_q == strap_s3_q) begin
            strap_val_q <= strap_s3_q;
         end
      end
   end

   // ==========================================
   // reset release sequencing
   // hold off the load until the strap chain has filled
   reg [2:0] rel_cnt_q;
   reg       load_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rel_cnt_q <= 3'h0;
         load_q    <= 1'b0;
      end else begin
         load_q <= 1'b0;
         if (rel_cnt_q != `PSC_REL_CYC) begin
            rel_cnt_q <= rel_cnt_q + 3'h1;
            if (rel_cnt_q == `PSC_REL_CYC - 3'h1) begin
               load_q <= 1'b1;
            end
         end
      end
   end

   // ==========================================
   // avalon slave
   // one wait cycle per access; the access acts where waitrequest is low
   wire req = avs_read | avs_write;
   wire acc = req & ~avs_waitrequest;
   wire wr  = acc & avs_write;
   wire we0 = wr & avs_byteenable[0];
   wire we1 = wr & avs_byteenable[1];

   reg [2:0] mode_reg_q;
   reg [15:0] srst_cnt_q;

   wire [15:0] ctrl_word = {soft_reset_q, 1'b0, speed_100_q, aneg_en_q, 1'b0,
                            isolate_q, 1'b0, full_duplex_q, 8'h00};
   wire [15:0] adv_word  = {7'h00, adv_q, 5'h00};
   wire [15:0] mode_word = {8'h00, mode_reg_q, station_address_q};
   wire [15:0] stat_word = {11'h000, config_valid_q, repeater_q, crs_on_tx_q,
                            soft_reset_q, power_down_q};

   // ==========================================
   // register read mux
   // unmapped offsets read as zero
   reg [15:0] rd_mux;

   always @* begin
      rd_mux = 16'h0000;
      case (avs_address)
         `PSC_IDX_CTRL: rd_mux = ctrl_word;
         `PSC_IDX_ADV:  rd_mux = adv_word;
         `PSC_IDX_MODE: rd_mux = mode_word;
         `PSC_IDX_STAT: rd_mux = stat_word;
         default:       rd_mux = 16'h0000;
      endcase
   end

   // ==========================================
   // register address decode
   wire hit_ctrl = hit(avs_address, `PSC_IDX_CTRL);
   wire hit_adv  = hit(avs_address, `PSC_IDX_ADV);
   wire hit_mode = hit(avs_address, `PSC_IDX_MODE);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
         if (req & avs_waitrequest) begin
            avs_readdata <= avs_read ? {16'h0000, rd_mux} : 32'h0000_0000;
         end
      end
   end

   // ==========================================
   // configuration registers
   wire [2:0] strap_mode_val = strap_val_q[7:5];
   wire       srst_done      = soft_reset_q & (srst_cnt_q == SRST_LAST);
   wire       srst_start     = we1 & hit_ctrl & avs_writedata[`PSC_CTL_SRST];
   wire       ctl_wr         = we1 & hit_ctrl;
   wire       adv_wr         = wr & hit_adv & avs_byteenable[0] & avs_byteenable[1];
   wire       mode_wr        = we0 & hit_mode;

   // station address: written only by the strap load, never by software
   // config_valid marks the first cycle the presets are in place
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         station_address_q <= 5'h00;
         config_valid_q    <= 1'b0;
      end else if (load_q) begin
         station_address_q <= strap_val_q[4:0];
         config_valid_q    <= 1'b1;
      end
   end

   // mode field: strap load first, software may change it afterwards
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg_q <= 3'h0;
      end else if (load_q) begin
         mode_reg_q <= strap_mode_val;
      end else if (mode_wr) begin
         mode_reg_q <= avs_writedata[`PSC_MODE_LSB +: 3];
      end
   end

   // control bits; a soft reset touches none of these, so straps never reach them again
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {speed_100_q, aneg_en_q, isolate_q, full_duplex_q} <= `PSC_CTL_RST;
      end else if (load_q) begin
         {speed_100_q, aneg_en_q, isolate_q, full_duplex_q} <= preset_ctl(strap_mode_val);
      end else if (ctl_wr) begin
         speed_100_q   <= avs_writedata[`PSC_CTL_SPEED];
         aneg_en_q     <= avs_writedata[`PSC_CTL_ANEG];
         isolate_q     <= avs_writedata[`PSC_CTL_ISO];
         full_duplex_q <= avs_writedata[`PSC_CTL_DUPLEX];
      end
   end

   // advertisement; the write needs both byte lanes since the field straddles them
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adv_q <= `PSC_ADV_RST;
      end else if (load_q) begin
         if (adv_loads(strap_mode_val)) begin
            adv_q <= preset_adv(strap_mode_val);
         end
      end else if (adv_wr) begin
         adv_q <= avs_writedata[`PSC_ADV_LSB +: 4];
      end
   end

   // carrier sense and repeater flags follow the strap code only
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crs_on_tx_q <= 1'b0;
         repeater_q  <= 1'b0;
      end else if (load_q) begin
         crs_on_tx_q <= crs_tx(strap_mode_val);
         repeater_q  <= (strap_mode_val == `PSC_MODE_RPT);
      end
   end

   // power-down: a soft reset is the only way out, and only once the mode field moved
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         power_down_q <= 1'b0;
      end else if (load_q) begin
         power_down_q <= (strap_mode_val == `PSC_MODE_PD);
      end else if (srst_done & (mode_reg_q != `PSC_MODE_PD)) begin
         power_down_q <= 1'b0;
      end
   end

   // ==========================================
   // soft reset sequencer
   // a fresh write of bit 15 in the finishing cycle restarts the wait
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_reset_q <= 1'b0;
         srst_cnt_q   <= 16'h0000;
      end else if (srst_start) begin
         soft_reset_q <= 1'b1;
         srst_cnt_q   <= 16'h0000;
      end else if (srst_done) begin
         soft_reset_q <= 1'b0;
         srst_cnt_q   <= 16'h0000;
      end else if (soft_reset_q) begin
         srst_cnt_q <= srst_cnt_q + 16'h0001;
      end
   end

   // ==========================================
   // management address match
   // an unconfigured part answers nobody, frames seen before the load are dropped
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_respond_q <= 1'b0;
      end else begin
         mgmt_respond_q <= mgmt_frame_valid & config_valid_q &
                           (mgmt_phy_addr == station_address_q);
      end
   end

   // ==========================================
   // transmit scrambler, x^11 + x^9 + 1
   // the pad keeps the seed nonzero even at station address 0
   // held at its seed while a soft reset runs, so the sequence restarts cleanly
   reg [10:0] scr_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scr_q     <= 11'h000;
         scr_bit_q <= 1'b0;
      end else if (load_q) begin
         scr_q     <= {`PSC_SCR_PAD, strap_val_q[4:0]};
         scr_bit_q <= 1'b0;
      end else if (soft_reset_q) begin
         scr_q     <= {`PSC_SCR_PAD, station_address_q};
         scr_bit_q <= 1'b0;
      end else if (config_valid_q & ~power_down_q) begin
         scr_q     <= {scr_q[9:0], scr_q[10] ^ scr_q[8]};
         scr_bit_q <= scr_q[10];
      end
   end

endmodule

// ===== dv/psc_strap_model.sv
// strap pin source standing outside the loader
module psc_strap_model (
   input  wire logic       clk,
   input  wire logic       wiggle,
   input  wire logic [4:0] addr_set,
   input  wire logic [2:0] mode_set,
   output logic      [4:0] strap_station_address,
   output logic      [2:0] strap_mode
);
   timeunit 1ns / 1ps;
   // pins stay put; wiggle only to prove late changes are ignored
   always @(posedge clk) begin
      strap_station_address <= wiggle ? ~strap_station_address : addr_set;
      strap_mode <= wiggle ? ~strap_mode : mode_set;
   end
endmodule

// ===== dv/psc_strap_loader_asserts.sv
// assertion checker for the strap configuration loader
module psc_strap_loader_asserts #(
   parameter int SOFT_RST_CYC = 20
) (
   input wire       clk,
   input wire       rst_n,
   input wire [2:0] strap_mode,
   input wire       mgmt_frame_valid,
   input wire [4:0] mgmt_phy_addr,
   input wire       mgmt_respond_q,
   input wire [4:0] station_address_q,
   input wire       speed_100_q,
   input wire       aneg_en_q,
   input wire       isolate_q,
   input wire       full_duplex_q,
   input wire [3:0] adv_q,
   input wire       crs_on_tx_q,
   input wire       repeater_q,
   input wire       power_down_q,
   input wire       soft_reset_q,
   input wire       config_valid_q
);
   timeunit 1ns / 1ps;
   // one nibble or bit per strap code; straps are steady at load
   localparam logic [31:0] CTL_T = 32'hd0cc_9810;
   localparam logic [31:0] ADV_T = 32'hf044_0000;
   localparam logic [7:0]  CRS_T = 8'h95;
   logic [15:0] cnt_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) cnt_q <= 16'h0000;
      else cnt_q <= soft_reset_q ? cnt_q + 16'h0001 : 16'h0000;
   chk_addr_held: assert property (
      config_valid_q && $past(config_valid_q) |-> $stable(station_address_q)) else $error("address moved");
   chk_mgmt_hit: assert property (
      mgmt_frame_valid && config_valid_q && mgmt_phy_addr == station_address_q |=> mgmt_respond_q)
      else $error("matching frame not answered");
   chk_mgmt_miss: assert property (
      mgmt_respond_q |-> $past(mgmt_frame_valid) && $past(mgmt_phy_addr) == $past(station_address_q))
      else $error("answer without matching frame");
   chk_mode_ctl: assert property (
      $rose(config_valid_q) |-> {speed_100_q, aneg_en_q, isolate_q, full_duplex_q} == CTL_T[{strap_mode, 2'h0} +: 4]
      && adv_q == ADV_T[{strap_mode, 2'h0} +: 4]) else $error("wrong mode defaults");
   chk_mode_crs: assert property (
      $rose(config_valid_q) |-> crs_on_tx_q == CRS_T[strap_mode] && repeater_q == (strap_mode == 3'h5)
      && power_down_q == (strap_mode == 3'h6)) else $error("wrong mode flags");
   chk_srst_keep: assert property (
      soft_reset_q |-> $stable(adv_q) && $stable(station_address_q)) else $error("soft reset reloaded");
   chk_pd_exit: assert property (
      $fell(power_down_q) |-> $fell(soft_reset_q)) else $error("power down left early");
   chk_srst_max: assert property (
      cnt_q <= SOFT_RST_CYC + 1) else $error("soft reset too long");
   chk_srst_min: assert property (
      $fell(soft_reset_q) |-> cnt_q >= SOFT_RST_CYC - 1) else $error("soft reset too short");
endmodule
bind psc_strap_loader psc_strap_loader_asserts #(.SOFT_RST_CYC(SOFT_RST_CYC)) u_chk (.*);

// ===== dv/psc_strap_loader_tb.sv
// self-checking bench for the strap configuration loader
module psc_strap_loader_tb;
   timeunit 1ns / 1ps;
   localparam logic [31:0] CTL_T = 32'hd0cc_9810;
   localparam logic [31:0] ADV_T = 32'hf044_0000;
   localparam logic [7:0]  CRS_T = 8'h95;
   logic        clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, mgmt_frame_valid = 0, wiggle = 0;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = '0, avs_readdata, rd, s1, s2, s3, a, seed = 32'h0000_3d3f;
   logic [3:0]  avs_byteenable = 4'h3, adv_q;
   logic [4:0]  mgmt_phy_addr = 5'h00, addr_set = 5'h00, strap_station_address, station_address_q;
   logic [2:0]  mode_set = 3'h0, strap_mode;
   logic        avs_waitrequest, mgmt_respond_q, speed_100_q, aneg_en_q, isolate_q, full_duplex_q;
   logic        crs_on_tx_q, repeater_q, power_down_q, soft_reset_q, config_valid_q, scr_bit_q;
   int          err_count = 0, n_checks = 0, m;
   // short soft reset keeps the run small
   psc_strap_loader #(.SOFT_RST_CYC(20)) u_psc_strap_loader (.*);
   psc_strap_model u_psc_strap_model (.*);
   initial forever #5 clk = ~clk;
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [31:0] ectl(input logic [2:0] md);
      logic [3:0] t;
      t = CTL_T[{md, 2'h0} +: 4];
      return {18'h0_0000, t[3], t[2], 1'h0, t[1], 1'h0, t[0], 8'h00};
   endfunction
   function logic [31:0] estat(input logic [2:0] md);
      return {28'h000_0001, md == 3'h5, CRS_T[md], 1'h0, md == 3'h6};
   endfunction
   task give_verdict();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int j;
      @(posedge clk);
      avs_address <= ad;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      for (j = 0; j < 40; j++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'h0) break;
      end
      rd = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (j == 40) begin
         err_count++;
         give_verdict();
      end
   endtask
   task mgmt(input logic [4:0] ad, input logic e);
      @(posedge clk);
      mgmt_frame_valid <= 1'h1;
      mgmt_phy_addr <= ad;
      @(posedge clk);
      mgmt_frame_valid <= 1'h0;
      @(posedge clk);
      cmp({31'h0, mgmt_respond_q}, {31'h0, e});
   endtask
   task do_reset(input logic [4:0] ad, input logic [2:0] md);
      @(posedge clk);
      rst_n <= 1'h0;
      addr_set <= ad;
      mode_set <= md;
      wiggle <= 1'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      repeat (8) @(posedge clk);
   endtask
   task cap(output logic [31:0] s);
      repeat (32) begin
         @(posedge clk);
         s = {s[30:0], scr_bit_q};
      end
   endtask
   // ====
   // every mode code, then scrambler seeding, then power-down exit
   initial begin
      for (m = 0; m < 8; m++) begin
         a = xs();
         do_reset(a[4:0], m[2:0]);
         wiggle <= 1'h1;
         bus(1'h0, 8'h00, '0);
         cmp(rd, ectl(m[2:0]));
         bus(1'h0, 8'h10, '0);
         cmp(rd, {23'h00_0000, ADV_T[{m[2:0], 2'h0} +: 4], 5'h00});
         bus(1'h0, 8'h80, '0);
         cmp(rd, estat(m[2:0]));
         bus(1'h0, 8'h48, '0);
         cmp(rd, {24'h00_0000, m[2:0], a[4:0]});
         mgmt(a[4:0], 1'h1);
         mgmt(a[4:0] ^ (a[9:5] | 5'h01), 1'h0);
      end
      bus(1'h1, 8'h44, 32'hffff_ffff);
      bus(1'h0, 8'h44, '0);
      cmp(rd, '0);
      do_reset(5'h03, 3'h0);
      cap(s1);
      do_reset(5'h1c, 3'h0);
      cap(s2);
      do_reset(5'h03, 3'h0);
      cap(s3);
      cmp(s3, s1);
      cmp({31'h0, s1 !== s2}, 32'h0000_0001);
      a = xs();
      do_reset(a[4:0], 3'h6);
      s1 = xs() & 32'h0000_01e0;
      bus(1'h1, 8'h10, s1);
      bus(1'h1, 8'h48, 32'h0000_0040);
      bus(1'h0, 8'h80, '0);
      cmp(rd, 32'h0000_0011);
      bus(1'h1, 8'h00, 32'h0000_8000);
      for (m = 0; m < 30; m++) begin
         bus(1'h0, 8'h80, '0);
         if (rd[1] === 1'h0) break;
      end
      cmp(rd, 32'h0000_0010);
      bus(1'h0, 8'h00, '0);
      cmp(rd, '0);
      bus(1'h0, 8'h10, '0);
      cmp(rd, s1);
      avs_byteenable <= 4'h1;
      bus(1'h1, 8'h10, ~s1);
      avs_byteenable <= 4'h3;
      bus(1'h0, 8'h10, '0);
      cmp(rd, s1);
      bus(1'h0, 8'h48, '0);
      cmp(rd, {24'h00_0000, 3'h2, a[4:0]});
      give_verdict();
   end
endmodule
